// ---- mtc_timer.sv ----
// mtc_timer.sv - modulo timer with two capture/compare/PWM channels, APB slave
//
// What this block does, and what software must do (RULE10, RULE22)
// RULE1 - halt bit freezes counter; reset sets halt
// RULE2 - clear bit zeroes counter and prescaler only
// RULE3 - clear bit self-clears, reads zero
// RULE4 - halt plus clear together: stopped at zero
// RULE5 - divider code picks bus clock /1../64
// RULE6 - high count read latches low byte
// RULE7 - count equals period: flag, then restart zero
// RULE8 - period high write locks flag until low
// RULE9 - period resets to all ones
// RULE10 - software clears counter before period writes
// RULE11 - channel flag on capture edge or match
// RULE12 - channel flag cleared by read-then-write-zero
// RULE13 - enable gates request; dma select routes it
// RULE14 - buffered bit disables channel one entirely
// RULE15 - unbuffered bit picks compare versus capture
// RULE16 - with pin off, unbuffered bit presets level
// RULE17 - edge/level zero releases pin to port
// RULE18 - capture on rising, falling or both
// RULE19 - compare toggles, clears or sets output
// RULE20 - wrap toggle flips compare output on overflow
// RULE21 - overflow toggle beats simultaneous compare
// RULE22 - software halts, clears before mode change
// RULE23 - wrap flag cleared by read-then-write-zero
// RULE24 - full duty forces full level next period, only while wrap toggle is clear
// RULE25 - counter steps once per enabled tick
`timescale 1ns/10ps
module mtc_timer
  import mtc_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [NCH-1:0] chan_pin_i, // channel pin levels
  output logic [NCH-1:0] chan_pin_o, // channel pin drive value
  output logic [NCH-1:0] chan_pin_oe, // channel pin drive enable
  output logic wrap_irq, // wrap interrupt request
  output logic [NCH-1:0] chan_irq, // channel cpu interrupt requests
  output logic [NCH-1:0] chan_dma_req // channel dma service requests
);

  // ==========================================================================
  // state
  logic [15:0] count_r;
  logic [7:0] low_latch_r;
  logic latched_r;
  logic halt_r;
  logic wrap_ie_r;
  logic wrap_flag_r;
  logic wrap_arm_r;
  logic [2:0] div_r;
  logic [15:0] period_r;
  logic period_lock_r;
  mtc_chan_ctrl_s ctl_r [NCH];
  logic [15:0] val_r [NCH];
  logic [NCH-1:0] cap_lock_r;
  logic [NCH-1:0] cmp_lock_r;
  logic [NCH-1:0] ch_arm_r;
  logic [NCH-1:0] hold_r;
  logic [NCH-1:0] pin_prev_r;
  logic [NCH-1:0] dma_sel_r;
  logic act_r;

  logic wr_ev;
  logic rd_ev;
  logic clear_req;
  logic tick;
  logic count_en;
  logic wrap_ev;
  logic wrap_set;
  logic [NCH-1:0] pin_s;
  logic [NCH-1:0] match;
  logic [NCH-1:0] capt;
  logic [NCH-1:0] ch_set;
  mtc_mode_e mode [NCH];

  // ==========================================================================
  // helpers
  function automatic logic [7:0] ctl_addr(input int x);
    return (x == 0) ? A_CH0_CTL : A_CH1_CTL;
  endfunction

  function automatic logic [7:0] hi_addr(input int x);
    return (x == 0) ? A_CH0_HI : A_CH1_HI;
  endfunction

  function automatic logic [7:0] lo_addr(input int x);
    return (x == 0) ? A_CH0_LO : A_CH1_LO;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a <= A_DMA_SEL) && (a[1:0] == 2'h0);
  endfunction

  // ==========================================================================
  // submodules
  mtc_prescaler #(.STAGES(PRESCALE_STAGES)) u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .clr(clear_req),
    .sel(div_r),
    .tick(tick)
  );

  mtc_pin_sync #(.W(NCH)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(chan_pin_i),
    .dout(pin_s)
  );

  // ==========================================================================
  // apb: one wait state so read data comes from a flip-flop
  assign rd_ev = psel && penable && !pready && !pwrite;
  assign wr_ev = psel && penable && pready && pwrite;
  assign clear_req = wr_ev && (paddr == A_CTRL) && pwdata[B_CLEAR]; // RULE3

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped(paddr);
      prdata <= '0;
      if (!pwrite) begin
        unique case (paddr)
          A_CTRL: prdata[7:0] <= {wrap_flag_r, wrap_ie_r, halt_r, 2'h0, div_r}; // RULE3
          A_CNT_HI: prdata[7:0] <= count_r[15:8];
          A_CNT_LO: prdata[7:0] <= latched_r ? low_latch_r : count_r[7:0]; // RULE6
          A_PER_HI: prdata[7:0] <= period_r[15:8];
          A_PER_LO: prdata[7:0] <= period_r[7:0];
          A_CH0_CTL: prdata[7:0] <= ctl_r[0];
          A_CH0_HI: prdata[7:0] <= val_r[0][15:8];
          A_CH0_LO: prdata[7:0] <= val_r[0][7:0];
          A_CH1_CTL: prdata[7:0] <= ctl_r[1];
          A_CH1_HI: prdata[7:0] <= val_r[1][15:8];
          A_CH1_LO: prdata[7:0] <= val_r[1][7:0];
          A_DMA_SEL: prdata[NCH-1:0] <= dma_sel_r;
          default: prdata <= '0;
        endcase
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================================
  // counter
  assign count_en = tick && !halt_r; // RULE1 RULE25
  assign wrap_ev = count_en && (count_r == period_r); // RULE7
  assign wrap_set = wrap_ev && !period_lock_r; // RULE8

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= CNT_RST;
    end else if (clear_req) begin
      count_r <= CNT_RST; // RULE2 RULE4
    end else if (count_en) begin
      count_r <= wrap_ev ? CNT_RST : count_r + 16'h0001; // RULE7 RULE25
    end
  end

  // low byte latch for coherent two-byte reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_r <= 1'b0;
      low_latch_r <= 8'h00;
    end else if (rd_ev && paddr == A_CNT_HI && !latched_r) begin
      latched_r <= 1'b1; // RULE6
      low_latch_r <= count_r[7:0];
    end else if (rd_ev && paddr == A_CNT_LO) begin
      latched_r <= 1'b0;
    end
  end

  // ==========================================================================
  // timer control and period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_r <= HALT_RST; // RULE1
      wrap_ie_r <= 1'b0;
      div_r <= DIV_RST; // RULE5
    end else if (wr_ev && paddr == A_CTRL) begin
      halt_r <= pwdata[B_HALT]; // RULE1 RULE4
      wrap_ie_r <= pwdata[B_WRAP_IE];
      div_r <= pwdata[DIV_W-1:0];
    end
  end

  // set wins over a clear in the same cycle; a set between read and write disarms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_flag_r <= 1'b0;
      wrap_arm_r <= 1'b0;
    end else if (wrap_set) begin
      wrap_flag_r <= 1'b1; // RULE7
      wrap_arm_r <= 1'b0; // RULE23
    end else if (wr_ev && paddr == A_CTRL) begin
      if (!pwdata[B_WRAP] && wrap_arm_r) begin
        wrap_flag_r <= 1'b0; // RULE23
      end
      wrap_arm_r <= 1'b0;
    end else if (rd_ev && paddr == A_CTRL && wrap_flag_r) begin
      wrap_arm_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_r <= PER_RST; // RULE9
      period_lock_r <= 1'b0;
    end else if (wr_ev && paddr == A_PER_HI) begin
      period_r[15:8] <= pwdata[7:0];
      period_lock_r <= 1'b1; // RULE8
    end else if (wr_ev && paddr == A_PER_LO) begin
      period_r[7:0] <= pwdata[7:0];
      period_lock_r <= 1'b0; // RULE8
    end
  end

  // ==========================================================================
  // channel mode decode and events
  always_comb begin
    for (int x = 0; x < NCH; x++) begin
      if (ctl_r[x].edge_level == ELS_OFF || (x == 1 && ctl_r[0].buffered)) begin
        mode[x] = MODE_OFF; // RULE14 RULE17
      end else if (ctl_r[x].buffered || ctl_r[x].unbuffered) begin
        mode[x] = MODE_COMPARE; // RULE15
      end else begin
        mode[x] = MODE_CAPTURE; // RULE15
      end
      // buffered pwm alternates between the two value registers each period
      match[x] = count_en && mode[x] == MODE_COMPARE && !cmp_lock_r[x]
        && count_r == ((x == 0 && ctl_r[0].buffered && act_r) ? val_r[1] : val_r[x]);
      capt[x] = mode[x] == MODE_CAPTURE && !cap_lock_r[x]
        && ((ctl_r[x].edge_level[0] && pin_s[x] && !pin_prev_r[x])
        || (ctl_r[x].edge_level[1] && !pin_s[x] && pin_prev_r[x])); // RULE18
      ch_set[x] = match[x] || capt[x]; // RULE11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_r <= '0;
    end else begin
      pin_prev_r <= pin_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_r <= 1'b0;
    end else if (!ctl_r[0].buffered) begin
      act_r <= 1'b0;
    end else if (wrap_ev) begin
      act_r <= !act_r;
    end
  end

  // ==========================================================================
  // channel control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int x = 0; x < NCH; x++) begin
        ctl_r[x] <= CHAN_CTRL_RST; // RULE12 RULE13 RULE14 RULE16 RULE17 RULE20
      end
      ch_arm_r <= '0;
    end else begin
      for (int x = 0; x < NCH; x++) begin
        if (wr_ev && paddr == ctl_addr(x) && !(x == 1 && ctl_r[0].buffered)) begin
          ctl_r[x].irq_en <= pwdata[6];
          ctl_r[x].buffered <= (x == 0) ? pwdata[5] : 1'b0; // RULE14
          ctl_r[x].unbuffered <= pwdata[4];
          ctl_r[x].edge_level <= pwdata[3:2];
          ctl_r[x].wrap_toggle <= pwdata[1];
          ctl_r[x].full_duty <= pwdata[0];
        end
        if (ch_set[x]) begin
          ctl_r[x].flag <= 1'b1; // RULE11
          ch_arm_r[x] <= 1'b0; // RULE12
        end else if (wr_ev && paddr == ctl_addr(x)) begin
          if (!pwdata[7] && ch_arm_r[x]) begin
            ctl_r[x].flag <= 1'b0; // RULE12
          end
          ch_arm_r[x] <= 1'b0;
        end else if (rd_ev && paddr == ctl_addr(x) && ctl_r[x].flag) begin
          ch_arm_r[x] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_sel_r <= '0;
    end else if (wr_ev && paddr == A_DMA_SEL) begin
      dma_sel_r <= pwdata[NCH-1:0];
    end
  end

  // ==========================================================================
  // channel value registers, capture and access locks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int x = 0; x < NCH; x++) begin
        val_r[x] <= CNT_RST;
      end
      cap_lock_r <= '0;
      cmp_lock_r <= '0;
    end else begin
      for (int x = 0; x < NCH; x++) begin
        if (wr_ev && paddr == hi_addr(x)) begin
          val_r[x][15:8] <= pwdata[7:0];
          cmp_lock_r[x] <= 1'b1;
        end else if (wr_ev && paddr == lo_addr(x)) begin
          val_r[x][7:0] <= pwdata[7:0];
          cmp_lock_r[x] <= 1'b0;
        end else if (capt[x]) begin
          val_r[x] <= count_r; // RULE11
        end
        if (rd_ev && paddr == hi_addr(x) && mode[x] == MODE_CAPTURE) begin
          cap_lock_r[x] <= 1'b1;
        end else if (rd_ev && paddr == lo_addr(x)) begin
          cap_lock_r[x] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // channel outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_pin_o <= '1;
      chan_pin_oe <= '0;
      hold_r <= '0;
    end else begin
      for (int x = 0; x < NCH; x++) begin
        chan_pin_oe[x] <= (mode[x] == MODE_COMPARE); // RULE17
        if (wrap_ev) begin
          hold_r[x] <= ctl_r[x].full_duty && !ctl_r[x].wrap_toggle; // RULE24
        end
        unique case (mode[x])
          MODE_OFF: chan_pin_o[x] <= !ctl_r[x].unbuffered; // RULE16
          MODE_CAPTURE: chan_pin_o[x] <= chan_pin_o[x];
          MODE_COMPARE: begin
            if (wrap_ev && ctl_r[x].wrap_toggle) begin
              chan_pin_o[x] <= !chan_pin_o[x]; // RULE20 RULE21
            end else if (hold_r[x]) begin
              // full level is the one that the compare action ends
              chan_pin_o[x] <= (ctl_r[x].edge_level == ELS_CLEAR); // RULE24
            end else if (match[x]) begin
              unique case (ctl_r[x].edge_level)
                ELS_TOGGLE: chan_pin_o[x] <= !chan_pin_o[x]; // RULE19
                ELS_CLEAR: chan_pin_o[x] <= 1'b0; // RULE19
                ELS_SET: chan_pin_o[x] <= 1'b1; // RULE19
                default: chan_pin_o[x] <= chan_pin_o[x];
              endcase
            end
          end
          default: chan_pin_o[x] <= chan_pin_o[x];
        endcase
      end
    end
  end

  // ==========================================================================
  // requests; dma select with enable set masks the cpu request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_irq <= 1'b0;
      chan_irq <= '0;
      chan_dma_req <= '0;
    end else begin
      wrap_irq <= wrap_flag_r && wrap_ie_r;
      for (int x = 0; x < NCH; x++) begin
        chan_irq[x] <= ctl_r[x].flag && ctl_r[x].irq_en && !dma_sel_r[x]; // RULE13
        chan_dma_req[x] <= ctl_r[x].flag && ctl_r[x].irq_en && dma_sel_r[x]; // RULE13
      end
    end
  end

endmodule

// ---- mtc_pkg.sv ----
// mtc_pkg.sv - register map, field layout and encodings of the modulo timer
package mtc_pkg;

  // ==========================================================================
  // register byte addresses, one aligned 32-bit word each
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CNT_HI = 8'h04;
  localparam logic [7:0] A_CNT_LO = 8'h08;
  localparam logic [7:0] A_PER_HI = 8'h0c;
  localparam logic [7:0] A_PER_LO = 8'h10;
  localparam logic [7:0] A_CH0_CTL = 8'h14;
  localparam logic [7:0] A_CH0_HI = 8'h18;
  localparam logic [7:0] A_CH0_LO = 8'h1c;
  localparam logic [7:0] A_CH1_CTL = 8'h20;
  localparam logic [7:0] A_CH1_HI = 8'h24;
  localparam logic [7:0] A_CH1_LO = 8'h28;
  localparam logic [7:0] A_DMA_SEL = 8'h2c;

  // ==========================================================================
  // timer_control_status fields
  localparam int unsigned B_WRAP = 7;
  localparam int unsigned B_WRAP_IE = 6;
  localparam int unsigned B_HALT = 5;
  localparam int unsigned B_CLEAR = 4;
  localparam int unsigned DIV_W = 3;
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [2:0] DIV_NONE = 3'h7;
  localparam logic HALT_RST = 1'b1;

  // ==========================================================================
  // counter and period
  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] PER_RST = 16'hffff;
  localparam int unsigned PRESCALE_STAGES = 6;

  // ==========================================================================
  // channel edge/level codes: capture edge, or compare action
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  localparam int unsigned NCH = 2;

  typedef struct packed {
    logic flag;
    logic irq_en;
    logic buffered;
    logic unbuffered;
    logic [1:0] edge_level;
    logic wrap_toggle;
    logic full_duty;
  } mtc_chan_ctrl_s;

  localparam mtc_chan_ctrl_s CHAN_CTRL_RST = 8'h00;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_COMPARE = 2'b10
  } mtc_mode_e;

endpackage

// ---- mtc_prescaler.sv ----
// mtc_prescaler.sv - divides the bus clock into a one-cycle counter tick
`timescale 1ns/10ps
module mtc_prescaler
  import mtc_pkg::*;
#(
  parameter int unsigned STAGES = PRESCALE_STAGES
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic clr, // restart the divider
  input wire logic [2:0] sel, // divider code
  output logic tick // one-cycle counter enable
);

  // ==========================================================================
  // checks
  if (STAGES < PRESCALE_STAGES) begin : g_chk
    $error("mtc_prescaler: STAGES too small for divide by 64");
  end

  logic [STAGES-1:0] div_r;
  logic [STAGES-1:0] mask;

  // ==========================================================================
  // divider
  assign mask = STAGES'((1 << sel) - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
      tick <= 1'b0;
    end else if (clr) begin // RULE2
      div_r <= '0;
      tick <= 1'b0;
    end else begin
      div_r <= div_r + 1'b1;
      tick <= (sel != DIV_NONE) && ((div_r & mask) == mask); // RULE5
    end
  end

endmodule

// ---- mtc_pin_sync.sv ----
// mtc_pin_sync.sv - three-stage synchroniser with agreement filter for pins
`timescale 1ns/10ps
module mtc_pin_sync #(
  parameter int unsigned W = 2
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic [W-1:0] din, // asynchronous pin levels
  output logic [W-1:0] dout // settled levels
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // ==========================================================================
  // sync chain; a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end

endmodule

// ---- mtc_timer_checker.sv ----
// mtc_timer_checker.sv - port-level assertions for the modulo timer
`timescale 1ns/10ps
module mtc_timer_checker
  import mtc_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [NCH-1:0] chan_pin_oe, // pin enables
  input wire logic [NCH-1:0] chan_irq, // cpu requests
  input wire logic [NCH-1:0] chan_dma_req // dma requests
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // bus phases
  logic done;
  logic bad;
  assign done = psel && penable && pready;
  assign bad = paddr > 8'h2c || paddr[1:0] != 2'h0;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  // ==========
  // assertions
  wait_one_a: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("ready not in second access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (done && bad |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (done && !bad |-> !pslverr)
    else $error("mapped access refused");
  upper_zero_a: assert property (done && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  clear_reads_zero_a: assert property (
    done && !pwrite && paddr == A_CTRL |-> !prdata[B_CLEAR])
    else $error("clear bit read as one");
  ch1_no_buf_a: assert property (
    done && !pwrite && paddr == A_CH1_CTL |-> !prdata[5])
    else $error("buffered bit seen in channel one");
  irq_route_a: assert property ((chan_irq & chan_dma_req) == 2'b00)
    else $error("cpu and dma request together");
  pin_release_a: assert property (
    done && pwrite && paddr == A_CH0_CTL && pwdata[3:2] == 2'h0 |-> ##2 !chan_pin_oe[0])
    else $error("channel zero pin driven");
  ch1_release_a: assert property (
    done && pwrite && paddr == A_CH0_CTL && pwdata[5] |-> ##2 !chan_pin_oe[1])
    else $error("channel one pin driven");
endmodule

bind mtc_timer mtc_timer_checker i_chk (.*);

// ---- mtc_cpu_model.sv ----
// mtc_cpu_model.sv - apb master standing in for the cpu
`timescale 1ns/10ps
module mtc_cpu_model
  import mtc_pkg::*;
(
  input wire logic pclk, // bus clock
  output logic psel, // apb select
  output logic penable, // apb access
  output logic pwrite, // apb direction
  output logic [7:0] paddr, // apb address
  output logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr // apb error
);
  logic [7:0] rdat;
  logic rerr;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // held until pready at a rising edge; only the bench watchdog ends a wait
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    d = rdat;
  endtask
  // stop and zero the counter before period or mode edits
  task halt_clr(input logic [2:0] div);
    wr(A_CTRL, 8'h30 | div);
  endtask
  // read arms the clear, write back with bit 7 low
  task clr_flag(input logic [7:0] a);
    logic [7:0] v;
    rd(a, v);
    wr(a, v & 8'h7f);
  endtask
endmodule

// ---- tb_mtc_timer.sv ----
// tb_mtc_timer.sv - self-checking bench for the modulo timer
`timescale 1ns/10ps
module tb_mtc_timer;
  import mtc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [NCH-1:0] pin_i = 2'b00;
  logic psel, penable, pwrite, pready, pslverr, wrap_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [NCH-1:0] pin_o, pin_oe, chan_irq, chan_dma_req;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  localparam logic [7:0] RA [6] = '{A_CTRL, A_PER_HI, A_PER_LO, A_CNT_LO, A_CH0_CTL, A_CH1_CTL};
  localparam logic [7:0] RV [6] = '{8'h20, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
  always #4 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  mtc_timer i_dut (.*, .chan_pin_i(pin_i), .chan_pin_o(pin_o), .chan_pin_oe(pin_oe));
  mtc_cpu_model i_cpu (.*);
  // ==========
  // helpers
  task cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // slack for prescaler phase
  task cmp_in(input string what, input int lo, input int hi, input logic [15:0] got);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("unexpected %s: expected %0d..%0d, seen %h", what, lo, hi, got);
    end
  endtask
  task rd_cnt(output logic [15:0] c);
    i_cpu.rd(A_CNT_HI, c[15:8]);
    i_cpu.rd(A_CNT_LO, c[7:0]);
  endtask
  task go(input logic [7:0] d);
    i_cpu.wr(A_CTRL, d);
  endtask
  task run(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========
  // tests
  task t_reset;
    logic [7:0] v;
    foreach (RA[k]) begin
      i_cpu.rd(RA[k], v);
      cmp("reset value", RV[k], v);
    end
    cmp("reset pin oe", 2'b00, pin_oe);
    i_cpu.rd(8'h30, v);
    cmp("unmapped error", 1'b1, i_cpu.rerr);
    $display("test reset done");
  endtask
  task t_count;
    logic [15:0] x, y;
    logic [7:0] v;
    go(8'h00);
    run(30);
    go(8'h20);
    rd_cnt(x);
    cmp_in("running count", 30, 40, x);
    run(10);
    rd_cnt(y);
    cmp("halted count", x, y);
    i_cpu.rd(A_CNT_HI, v);
    go(8'h00);
    run(20);
    i_cpu.rd(A_CNT_HI, v);
    go(8'h20);
    i_cpu.rd(A_CNT_LO, v);
    cmp("latched low byte", x[7:0], v);
    i_cpu.halt_clr(3'h0);
    rd_cnt(x);
    cmp("count after clear", 16'h0000, x);
    i_cpu.rd(A_CTRL, v);
    cmp("ctrl after clear", 8'h20, v);
    go(8'h10);
    go(8'h20);
    rd_cnt(x);
    cmp_in("restart from zero", 1, 8, x);
    i_cpu.rd(A_PER_HI, v);
    cmp("period untouched", 8'hff, v);
    $display("test count done");
  endtask
  task t_div;
    logic [15:0] c;
    int t0, e;
    for (int k = 0; k < 8; k++) begin
      i_cpu.halt_clr(k[2:0]);
      go(8'h10 | k[7:0]);
      t0 = cyc;
      run(200);
      go(8'h20 | k[7:0]);
      e = (k == 7) ? 0 : (cyc - t0) >> k;
      rd_cnt(c);
      cmp_in("divided count", (e > 0) ? e - 1 : 0, e + (k < 7), c);
    end
    $display("test divider done");
  endtask
  task t_wrap;
    logic [7:0] v;
    logic [15:0] c;
    i_cpu.halt_clr(3'h0);
    i_cpu.wr(A_PER_HI, 8'h00);
    i_cpu.wr(A_PER_LO, 8'h0f);
    i_cpu.wr(A_PER_HI, 8'h00);
    go(8'h40);
    run(60);
    go(8'h60);
    i_cpu.rd(A_CTRL, v);
    cmp("flag while locked", 1'b0, v[B_WRAP]);
    cmp("irq while locked", 1'b0, wrap_irq);
    i_cpu.wr(A_PER_LO, 8'h0f);
    go(8'h40);
    run(60);
    go(8'h60);
    rd_cnt(c);
    cmp_in("count within period", 0, 15, c);
    i_cpu.rd(A_CTRL, v);
    cmp("wrap flag", 1'b1, v[B_WRAP]);
    cmp("wrap irq", 1'b1, wrap_irq);
    go(v);
    i_cpu.rd(A_CTRL, v);
    cmp("flag after writing one", 1'b1, v[B_WRAP]);
    i_cpu.clr_flag(A_CTRL);
    i_cpu.rd(A_CTRL, v);
    cmp("flag cleared", 1'b0, v[B_WRAP]);
    cmp("irq cleared", 1'b0, wrap_irq);
    go(8'h00);
    run(40);
    i_cpu.rd(A_CTRL, v);
    run(20);
    go(8'h20);
    i_cpu.rd(A_CTRL, v);
    cmp("new wrap keeps flag", 1'b1, v[B_WRAP]);
    i_cpu.clr_flag(A_CTRL);
    $display("test wrap done");
  endtask
  task t_compare;
    logic [7:0] v;
    i_cpu.wr(A_CH0_HI, 8'h00);
    i_cpu.wr(A_CH0_LO, 8'h05);
    for (int k = 1; k < 4; k++) begin
      i_cpu.halt_clr(3'h0);
      i_cpu.wr(A_CH0_CTL, k[0] ? 8'h10 : 8'h00);
      i_cpu.wr(A_CH0_CTL, 8'h50 | {k[5:0], 2'b00});
      run(2);
      cmp("compare pin oe", 1'b1, pin_oe[0]);
      cmp("preset level", !k[0], pin_o[0]);
      go(8'h00);
      run(6);
      go(8'h20);
      cmp("compare output", k[0], pin_o[0]);
      i_cpu.rd(A_CH0_CTL, v);
      cmp("channel flag", 1'b1, v[7]);
      cmp("cpu request", 1'b1, chan_irq[0]);
      i_cpu.wr(A_DMA_SEL, 8'h01);
      run(2);
      cmp("dma request", 2'b01, {chan_irq[0], chan_dma_req[0]});
      i_cpu.wr(A_DMA_SEL, 8'h00);
      i_cpu.clr_flag(A_CH0_CTL);
      run(2);
      cmp("request cleared", 1'b0, chan_irq[0]);
    end
    $display("test compare done");
  endtask
  task t_capture;
    for (int k = 1; k < 4; k++) begin
      i_cpu.halt_clr(3'h0);
      i_cpu.wr(A_CH1_CTL, 8'h40 | {k[5:0], 2'b00});
      go(8'h00);
      pin_i[1] <= 1'b1;
      run(8);
      cmp("rising capture", k[0], chan_irq[1]);
      i_cpu.clr_flag(A_CH1_CTL);
      pin_i[1] <= 1'b0;
      run(8);
      cmp("falling capture", k[1], chan_irq[1]);
      i_cpu.clr_flag(A_CH1_CTL);
      cmp("capture pin oe", 1'b0, pin_oe[1]);
    end
    $display("test capture done");
  endtask
  task t_buffered;
    logic [7:0] v;
    i_cpu.halt_clr(3'h0);
    i_cpu.wr(A_CH1_CTL, 8'h14);
    run(2);
    cmp("ch1 driven", 1'b1, pin_oe[1]);
    i_cpu.wr(A_CH0_CTL, 8'h24);
    run(2);
    cmp("ch1 released", 1'b0, pin_oe[1]);
    i_cpu.wr(A_CH1_CTL, 8'h18);
    i_cpu.rd(A_CH1_CTL, v);
    cmp("ch1 write ignored", 8'h14, v & 8'h7f);
    i_cpu.wr(A_CH0_CTL, 8'h00);
    run(2);
    cmp("ch0 released", 1'b0, pin_oe[0]);
    $display("test buffered done");
  endtask
  // ==========
  // sequence and watchdog
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_count;
    t_div;
    t_wrap;
    t_compare;
    t_capture;
    t_buffered;
    stop_test;
  end
  // tests need under 10k cycles
  initial begin
    #200us;
    miscompares++;
    $display("watchdog expired");
    stop_test;
  end
endmodule
